// ==== cmp_ctrl.sv ====
// digital control of the dual comparator: registers, pin muxing, change flag
//
// Summary of operation
// - result bit high when plus input exceeds minus
// - mode 010 puts internal reference on plus
// - mode 110 drives pins from raw results
// - direction bits still gate pin drivers
// - result bits readable, writes to them ignored
// - flag set when results differ from latched
// - flag cleared by writing zero, one sets it
// - request needs all three enables; flag regardless
// - any control register access latches results
// - mismatch keeps setting flag until access
// - change during control read still sets flag
// - comparators run in sleep and wake device
// - mode 111 switches both comparators off
// - wake from sleep leaves control unchanged
// - reset gives mode 000, pins 0 to 3 analog
// - comparators powered down throughout reset
// - port reads return zero on analog pins
// - mode field selects one of eight configurations
`timescale 1ns/1ps
module cmp_ctrl #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// analog comparator side
	input  wire logic [1:0]        cmp_result_i,
	output logic      [1:0]        cmp_power_o,
	output logic      [2:0]        cmp_mode_o,
	output logic                   input_switch_o,
	output logic                   int_ref_select_o,
	output logic      [7:0]        ref_control_o,
	// port a pins
	input  wire logic [4:0]        port_a_pins_i,
	input  wire logic [4:3]        port_a_latch_i,
	output logic      [4:0]        port_a_read_o,
	output logic                   port_a_pin3_o,
	output logic                   port_a_pin3_oe_o,
	output logic                   port_a_pin4_o,
	output logic                   port_a_pin4_oe_o,
	// interrupt and wake
	output logic                   irq_o,
	output logic                   wake_o
);

	// the register map needs the top index times four to fit
	if (ADDR_W < 10) begin : g_addr_w_check
		$error("cmp_ctrl: ADDR_W must be at least 10");
	end

	typedef struct packed {
		logic [2:0]  comparator_mode_field;
		logic        input_switch_select;
		logic [7:0]  irq_control_reg;
		logic        compare_change_flag;
		logic        compare_change_irq_enable;
		logic [4:0]  port_a_direction_reg;
		logic [7:0]  reference_control_reg;
		logic [1:0]  ref_latch;
		logic [1:0]  power;
		logic        int_ref;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [4:0]  port_read;
		logic [1:0]  pin_oe;
		logic        irq;
		logic        wake;
	} ctrl_state_s;

	ctrl_state_s state_reg;
	ctrl_state_s state_next;

	cmp_sync_if sync_bus ();

	cmp_sync u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.bus       (sync_bus.sync_side)
	);

	assign sync_bus.raw = cmp_result_i;

	// address hit on a register index, word aligned
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction : reg_hit

	// port a pins 0 to 3 that each mode keeps analog
	function automatic logic [3:0] analog_mask(input logic [2:0] mode);
		unique case (cmp_ctrl_pkg::cmp_mode_e'(mode))
			cmp_ctrl_pkg::MODE_OFF:     analog_mask = 4'h0;
			cmp_ctrl_pkg::MODE_PIN_OUT: analog_mask = 4'h7;
			cmp_ctrl_pkg::MODE_SHARED:  analog_mask = 4'h7;
			default:                    analog_mask = 4'hf;
		endcase
	endfunction : analog_mask

	// comparators that a mode keeps running
	function automatic logic [1:0] mode_power(input logic [2:0] mode);
		unique case (cmp_ctrl_pkg::cmp_mode_e'(mode))
			cmp_ctrl_pkg::MODE_RESET:    mode_power = 2'h0;
			cmp_ctrl_pkg::MODE_OFF:      mode_power = 2'h0;
			cmp_ctrl_pkg::MODE_ONE_ONLY: mode_power = 2'h2;
			default:                     mode_power = 2'h3;
		endcase
	endfunction : mode_power

	logic       hit_any;
	logic       access;
	logic       do_write;
	logic       cmp_touch;
	logic [1:0] cmp_now;
	logic       mismatch;
	logic [7:0] rd_byte;

	always_comb begin
		state_next = state_reg;
		hit_any    = reg_hit(paddr_i, cmp_ctrl_pkg::IDX_IRQ_CTRL)
		           | reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_FLAG)
		           | reg_hit(paddr_i, cmp_ctrl_pkg::IDX_CMP_CTRL)
		           | reg_hit(paddr_i, cmp_ctrl_pkg::IDX_DIR_A)
		           | reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_EN)
		           | reg_hit(paddr_i, cmp_ctrl_pkg::IDX_REF_CTRL);
		access     = psel_i & penable_i & state_reg.pready;
		do_write   = access & pwrite_i & hit_any;
		cmp_touch  = access & reg_hit(paddr_i, cmp_ctrl_pkg::IDX_CMP_CTRL);

		// synchronised results, zero while a comparator is powered down
		cmp_now  = sync_bus.synced & state_reg.power;
		mismatch = (cmp_now != state_reg.ref_latch);

		// read data, assembled in the setup cycle
		rd_byte = 8'h00;
		if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_IRQ_CTRL)) begin
			rd_byte = state_reg.irq_control_reg;
		end else if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_FLAG)) begin
			rd_byte[cmp_ctrl_pkg::POS_CMP_FLAG] = state_reg.compare_change_flag;
		end else if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_CMP_CTRL)) begin
			rd_byte = {cmp_now[1], cmp_now[0], 2'b00,
				state_reg.input_switch_select, state_reg.comparator_mode_field};
		end else if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_DIR_A)) begin
			rd_byte = {3'b000, state_reg.port_a_direction_reg};
		end else if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_EN)) begin
			rd_byte[cmp_ctrl_pkg::POS_CMP_IE] = state_reg.compare_change_irq_enable;
		end else if (reg_hit(paddr_i, cmp_ctrl_pkg::IDX_REF_CTRL)) begin
			rd_byte = state_reg.reference_control_reg;
		end

		// no wait state: pready and read data are registered in the setup cycle
		state_next.pready  = psel_i & ~penable_i;
		state_next.pslverr = psel_i & ~penable_i & ~hit_any;
		state_next.prdata  = (psel_i & ~penable_i & ~pwrite_i) ? {24'h000000, rd_byte} : 32'h0;

		// register writes take effect at the completing edge only
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_IRQ_CTRL)) begin
			state_next.irq_control_reg = pwdata_i[7:0];
		end
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_CMP_CTRL)) begin
			state_next.comparator_mode_field = pwdata_i[2:0];
			state_next.input_switch_select   = pwdata_i[cmp_ctrl_pkg::POS_IN_SWITCH];
		end
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_DIR_A)) begin
			state_next.port_a_direction_reg = pwdata_i[4:0];
		end
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_EN)) begin
			state_next.compare_change_irq_enable = pwdata_i[cmp_ctrl_pkg::POS_CMP_IE];
		end
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_REF_CTRL)) begin
			state_next.reference_control_reg = pwdata_i[7:0] & cmp_ctrl_pkg::REF_CTRL_MASK;
		end

		// flag: software write first, hardware set wins over a clear
		if (do_write && reg_hit(paddr_i, cmp_ctrl_pkg::IDX_PER_FLAG)) begin
			state_next.compare_change_flag = pwdata_i[cmp_ctrl_pkg::POS_CMP_FLAG];
		end
		if (mismatch) begin
			state_next.compare_change_flag = 1'b1;
		end

		// any read or write of the control register ends the mismatch;
		// a result that changes in that very cycle is taken as the new
		// reference and still raises the flag
		if (cmp_touch) begin
			state_next.ref_latch = cmp_now;
		end

		// analog side follows the registered mode; sleep leaves it alone
		state_next.power   = mode_power(state_next.comparator_mode_field);
		state_next.int_ref = (state_next.comparator_mode_field ==
			cmp_ctrl_pkg::MODE_INT_REF);

		// pins: analog ones read as zero, drivers gated by direction
		state_next.port_read = port_a_pins_i &
			~{1'b0, analog_mask(state_next.comparator_mode_field)};
		state_next.pin_oe    = ~state_next.port_a_direction_reg[4:3];

		// request needs every enable; wake needs only the local one
		state_next.irq  = state_next.compare_change_flag
			& state_next.compare_change_irq_enable
			& state_next.irq_control_reg[cmp_ctrl_pkg::POS_PERIPH_EN]
			& state_next.irq_control_reg[cmp_ctrl_pkg::POS_GLOBAL_EN];
		state_next.wake = state_next.compare_change_flag
			& state_next.compare_change_irq_enable;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg                       <= '0;
			state_reg.comparator_mode_field <= cmp_ctrl_pkg::RST_CMP_CTRL[2:0];
			state_reg.irq_control_reg       <= cmp_ctrl_pkg::RST_IRQ_CTRL;
			state_reg.port_a_direction_reg  <= cmp_ctrl_pkg::RST_DIR_A;
			state_reg.reference_control_reg <= cmp_ctrl_pkg::RST_REF_CTRL;
			state_reg.power                 <= 2'h0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata_o         = state_reg.prdata;
	assign pready_o         = state_reg.pready;
	assign pslverr_o        = state_reg.pslverr;
	assign cmp_power_o      = state_reg.power;
	assign cmp_mode_o       = state_reg.comparator_mode_field;
	assign input_switch_o   = state_reg.input_switch_select;
	assign int_ref_select_o = state_reg.int_ref;
	assign ref_control_o    = state_reg.reference_control_reg;
	assign port_a_read_o    = state_reg.port_read;
	assign port_a_pin3_oe_o = state_reg.pin_oe[0];
	assign port_a_pin4_oe_o = state_reg.pin_oe[1];
	assign irq_o            = state_reg.irq;
	assign wake_o           = state_reg.wake;

	// raw results reach the pins with no register: the pin must follow
	// the comparator itself, at the price of a glitch-prone output
	assign port_a_pin3_o = (state_reg.comparator_mode_field == cmp_ctrl_pkg::MODE_PIN_OUT)
		? cmp_result_i[0] : port_a_latch_i[3];
	assign port_a_pin4_o = (state_reg.comparator_mode_field == cmp_ctrl_pkg::MODE_PIN_OUT)
		? cmp_result_i[1] : port_a_latch_i[4];

endmodule : cmp_ctrl

// ==== cmp_ctrl_pkg.sv ====
// constants, field positions and modes of the dual comparator control block
package cmp_ctrl_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_IRQ_CTRL  = 8'h0b;
	localparam logic [7:0] IDX_PER_FLAG  = 8'h0c;
	localparam logic [7:0] IDX_CMP_CTRL  = 8'h1f;
	localparam logic [7:0] IDX_DIR_A     = 8'h85;
	localparam logic [7:0] IDX_PER_EN    = 8'h8c;
	localparam logic [7:0] IDX_REF_CTRL  = 8'h9f;

	// reset values
	localparam logic [7:0] RST_IRQ_CTRL  = 8'h00;
	localparam logic [7:0] RST_CMP_CTRL  = 8'h00;
	localparam logic [4:0] RST_DIR_A     = 5'h1f;
	localparam logic [7:0] RST_REF_CTRL  = 8'h00;

	// field positions
	localparam int         POS_GLOBAL_EN = 7;
	localparam int         POS_PERIPH_EN = 6;
	localparam int         POS_CMP_FLAG  = 6;
	localparam int         POS_CMP_IE    = 6;
	localparam int         POS_IN_SWITCH = 3;
	localparam logic [7:0] REF_CTRL_MASK = 8'hef;

	// operating modes of the comparator pair
	typedef enum logic [2:0] {
		MODE_RESET    = 3'b000,
		MODE_ONE_REF  = 3'b001,
		MODE_INT_REF  = 3'b010,
		MODE_SHARED   = 3'b011,
		MODE_TWO_IND  = 3'b100,
		MODE_ONE_ONLY = 3'b101,
		MODE_PIN_OUT  = 3'b110,
		MODE_OFF      = 3'b111
	} cmp_mode_e;

endpackage : cmp_ctrl_pkg

// ==== cmp_sync_if.sv ====
// carrier between comparator control and its input synchroniser
`timescale 1ns/1ps
interface cmp_sync_if;
	logic [1:0] raw;
	logic [1:0] synced;

	modport sync_side (input raw, output synced);
	modport ctrl_side (output raw, input synced);
endinterface : cmp_sync_if

// ==== cmp_sync.sv ====
// two-stage synchroniser for the asynchronous comparator results
`timescale 1ns/1ps
module cmp_sync (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// raw in, synchronised out
	cmp_sync_if.sync_side    bus
);

	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
	} sync_state_s;

	sync_state_s state_reg;
	sync_state_s state_next;

	// stage1 feeds stage2 only, to give metastability a full cycle
	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = bus.raw;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.synced = state_reg.stage2;

endmodule : cmp_sync

// ==== cmp_ctrl_properties.sv ====
// concurrent checks on the comparator control ports
`timescale 1ns/1ps
module cmp_ctrl_checker #(
	parameter int ADDR_W = 10
) (
	// clock, reset and bus
	input wire logic              clk_i,
	input wire logic              reset_n_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0]       prdata_o,
	input wire logic              pready_o,
	// comparator, pins, interrupt
	input wire logic [1:0]        cmp_result_i,
	input wire logic [1:0]        cmp_power_o,
	input wire logic [2:0]        cmp_mode_o,
	input wire logic              int_ref_select_o,
	input wire logic [4:3]        port_a_latch_i,
	input wire logic [4:0]        port_a_read_o,
	input wire logic              port_a_pin3_o,
	input wire logic              irq_o,
	input wire logic              wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence rd_cmp;
		psel_i && penable_i && pready_o && !pwrite_i && paddr_i == ADDR_W'(10'h07c);
	endsequence
	reset_idle_a: assert property (disable iff (1'b0) !reset_n_i |-> cmp_mode_o == 3'h0 && cmp_power_o == 2'h0)
		else $error("mode or power not cleared in reset");
	apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no answer after setup");
	ro_bits_a: assert property (rd_cmp |-> prdata_o[5:4] == 2'h0 && prdata_o[31:8] == 24'h0)
		else $error("unused control bits not zero");
	off_read_a: assert property (rd_cmp |-> cmp_mode_o != 3'h7 || prdata_o[7:6] == 2'h0)
		else $error("results shown while off");
	ref_select_a: assert property (int_ref_select_o == (cmp_mode_o == 3'h2))
		else $error("internal reference select wrong");
	pin_mux_a: assert property (port_a_pin3_o == (cmp_mode_o == 3'h6 ? cmp_result_i[0] : port_a_latch_i[3]))
		else $error("pin3 source wrong");
	power_off_a: assert property (cmp_mode_o == 3'h7 |-> cmp_power_o == 2'h0)
		else $error("power on in off mode");
	single_power_a: assert property (cmp_mode_o == 3'h5 |-> cmp_power_o == 2'h2)
		else $error("single comparator power wrong");
	analog_low_a: assert property (cmp_mode_o != 3'h7 |-> port_a_read_o[2:0] == 3'h0)
		else $error("analog pins read nonzero");
	analog_pin3_a: assert property (!(cmp_mode_o inside {3'h3, 3'h6, 3'h7}) |-> !port_a_read_o[3])
		else $error("analog pin3 read nonzero");
	irq_gate_a: assert property (irq_o |-> wake_o)
		else $error("request without enabled flag");
endmodule : cmp_ctrl_checker
bind cmp_ctrl cmp_ctrl_checker #(.ADDR_W(ADDR_W)) chk (.clk_i, .reset_n_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .prdata_o, .pready_o, .cmp_result_i, .cmp_power_o, .cmp_mode_o,
	.int_ref_select_o, .port_a_latch_i, .port_a_read_o, .port_a_pin3_o, .irq_o, .wake_o);

// ==== cmp_src_model.sv ====
// analog source model: two comparators with finite response time
`timescale 1ns/1ps
module cmp_src_model (
	// levels, one byte per comparator
	input  wire logic [15:0] plus_i,
	input  wire logic [15:0] minus_i,
	input  wire logic        slow_i,
	// raw results
	output logic      [1:0]  result_o
);
	logic [1:0] cmp_next;
	assign cmp_next = {plus_i[15:8] > minus_i[15:8], plus_i[7:0] > minus_i[7:0]};
	initial result_o = 2'h0;
	// results settle only after the response time
	always @(cmp_next) result_o <= #(slow_i ? 730 : 35) cmp_next;
endmodule : cmp_src_model

// ==== test_dual_comparator_control.sv ====
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module test_dual_comparator_control;
	logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, slow;
	logic        irq_o, wake_o, input_switch_o, int_ref_select_o;
	logic        port_a_pin3_o, port_a_pin3_oe_o, port_a_pin4_o, port_a_pin4_oe_o;
	logic [9:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rng, v;
	logic [1:0]  cmp_result_i, cmp_power_o;
	logic [2:0]  cmp_mode_o;
	logic [7:0]  ref_control_o, p, q;
	logic [4:0]  port_a_pins_i, port_a_read_o;
	logic [4:3]  port_a_latch_i;
	logic [15:0] plus, minus;
	logic [32:0] exp_q[$];
	logic [9:0]  ra[6] = '{10'h02c, 10'h030, 10'h07c, 10'h214, 10'h230, 10'h27c};
	int          n_fail, n_tests, cyc;
	cmp_ctrl #(.ADDR_W(10)) dut (.*);
	cmp_src_model src (.plus_i(plus), .minus_i(minus), .slow_i(slow), .result_o(cmp_result_i));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task finish_test();
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic w(int n);
		repeat (n) @(posedge clk_i);
	endtask : w
	// request held until pready is seen at an edge
	task automatic apb(logic wr, logic [9:0] a, logic [7:0] d, logic [32:0] e);
		if (!wr)
			exp_q.push_back(e);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// one idle edge so the next call never re-drives psel in this step
		@(posedge clk_i);
	endtask : apb
	task automatic rd(logic [9:0] a, logic [7:0] d, logic e = 1'b0);
		apb(1'b0, a, 8'h0, {e, 24'h0, d});
	endtask : rd
	task automatic wr(logic [9:0] a, logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic lv(logic [1:0] r);
		v = xs();
		p = {1'b1, v[6:0]};
		q = {1'b0, v[14:8]};
		plus <= {r[1] ? p : q, r[0] ? p : q};
		minus <= {r[1] ? q : p, r[0] ? q : p};
	endtask : lv
	always @(posedge clk_i) begin
		cyc++;
		if (psel_i && penable_i && pready_o && !pwrite_i)
			chk("read", {pslverr_o, prdata_o}, exp_q.pop_front());
		if (cyc > 20000) begin
			n_fail++;
			finish_test();
		end
	end
	initial forever #50 clk_i = ~clk_i;
	initial begin
		{clk_i, psel_i, penable_i, pwrite_i, slow} = 5'h0;
		// non-blocking so the design's reset process sees the falling edge
		reset_n_i <= 1'b0;
		{paddr_i, pwdata_i, plus, minus, port_a_pins_i, port_a_latch_i} = 81'h0;
		{n_fail, n_tests, cyc} = '0;
		rng = 32'd6400;
		repeat (6) @(posedge clk_i);
		chk("power", cmp_power_o, 0);
		reset_n_i <= 1'b1;
		foreach (ra[i]) rd(ra[i], i == 3 ? 8'h1f : 8'h00);
		rd(10'h100, 8'h00, 1'b1);
		wr(10'h07c, 8'hff);
		rd(10'h07c, 8'h0f);
		chk("switch", {input_switch_o, cmp_mode_o}, 4'hf);
		wr(10'h27c, 8'hff);
		rd(10'h27c, 8'hef);
		chk("refctl", ref_control_o, 8'hef);
		for (int m = 0; m < 8; m++) begin
			v = xs();
			port_a_pins_i <= v[4:0];
			port_a_latch_i <= v[6:5];
			wr(10'h07c, m[7:0]);
			w(2);
			chk("power", cmp_power_o, m == 0 || m == 7 ? 0 : m == 5 ? 2 : 3);
			chk("refsel", int_ref_select_o, m == 2);
			chk("port", port_a_read_o, port_a_pins_i & (m == 7 ? 5'h1f : m == 6 || m == 3 ? 5'h18 : 5'h10));
		end
		wr(10'h214, 8'h07);
		wr(10'h07c, 8'h06);
		slow <= 1'b1;
		lv(2'b01);
		w(12);
		chk("pins", {port_a_pin4_o, port_a_pin3_o, port_a_pin4_oe_o, port_a_pin3_oe_o}, 4'h7);
		wr(10'h214, 8'h1f);
		w(1);
		chk("oe", {port_a_pin4_oe_o, port_a_pin3_oe_o}, 0);
		wr(10'h07c, 8'h02);
		wr(10'h230, 8'h40);
		wr(10'h02c, 8'hc0);
		w(12);
		rd(10'h07c, 8'h42);
		wr(10'h030, 8'h00);
		w(2);
		chk("irq", {irq_o, wake_o}, 0);
		lv(2'b10);
		w(12);
		chk("irq", {irq_o, wake_o}, 3);
		wr(10'h030, 8'h00);
		rd(10'h030, 8'h40);
		rd(10'h07c, 8'h82);
		wr(10'h030, 8'h00);
		rd(10'h030, 8'h00);
		wr(10'h030, 8'h40);
		wr(10'h02c, 8'h40);
		w(1);
		chk("irq", {irq_o, wake_o}, 1);
		reset_n_i <= 1'b0;
		w(1);
		chk("power", cmp_power_o, 0);
		reset_n_i <= 1'b1;
		rd(10'h07c, 8'h00);
		wr(10'h07c, 8'h02);
		rd(10'h07c, 8'h82);
		wr(10'h07c, 8'h07);
		rd(10'h07c, 8'h07);
		w(2);
		finish_test();
	end
endmodule : test_dual_comparator_control
